// ### logic/cag_defs.vh
`ifndef CAG_DEFS_VH
`define CAG_DEFS_VH

// Request kinds (one-hot not needed; plain code on req_mode)
`define CAG_M_ABS 4'h0
`define CAG_M_TABLE 4'h1
`define CAG_M_REGJMP 4'h2
`define CAG_M_REL 4'h3
`define CAG_M_DIRECT 4'h4
`define CAG_M_SHORT 4'h5
`define CAG_M_SFR 4'h6
`define CAG_M_REG 4'h7
`define CAG_M_INDIR 4'h8
`define CAG_M_BASED 4'h9
`define CAG_M_PUSH 4'hA
`define CAG_M_POP 4'hB

// Table call area
`define CAG_TABLE_BASE 16'h0040
`define CAG_TABLE_LAST 16'h007F
`define CAG_SLOT_LSB 1
`define CAG_SLOT_MSB 5

// Short direct window and SFR space
`define CAG_SHORT_LOW 16'hFE20
`define CAG_SHORT_HIGH 16'hFF1F
`define CAG_RAM_LAST 16'hFEFF
`define CAG_SFR_BASE 16'hFF00
`define CAG_SFR_LAST 16'hFFFF
`define CAG_SHORT_SPLIT 8'h20
`define CAG_UPPER_ONES 7'h7F

// Pair select codes
`define CAG_PAIR_ACC 2'h0
`define CAG_PAIR_CNT 2'h1
`define CAG_PAIR_IDX 2'h2
`define CAG_PAIR_BASE 2'h3

`define CAG_SP_RESET 16'hFF00

`endif

// ### logic/cag_addr_gen.v
`timescale 1ns/100ps
`include "cag_defs.vh"

// Overview of operation
// - Absolute call/jump loads 16-bit target
// - Table call slot from instruction bits 1-5
// - Table sits at 40H-7FH; fetched entry
// - Register jump loads accumulator pair
// - Direct mode uses 16-bit operand unchanged
// - Short direct maps into FE20H-FF1FH
// - Bit 8 set for 00H-1FH, cleared otherwise
// - RAM FE20H-FEFFH, SFRs FF00H-FF1FH
// - SFR mode addresses FF00H-FFFFH
// - Register mode: eight bytes or four pairs
// - Indirect uses index or base pair
// - Based adds zero-extended offset, carry dropped
// - Stack accesses go through stack pointer
// - Relative jump adds signed displacement
module cag_addr_gen #(
    parameter AW = 16
) (
    input wire clk_sys,
    input wire reset_n,
    input wire req_valid,
    input wire [3:0] req_mode,
    input wire [15:0] full_address_operand,
    input wire [7:0] opcode,
    input wire [7:0] byte_operand,
    input wire [7:0] jump_displacement,
    input wire [15:0] next_pc,
    input wire [1:0] pair_select_field,
    input wire [2:0] reg_code,
    input wire [15:0] accumulator_pair,
    input wire [15:0] counter_pair,
    input wire [15:0] index_pair,
    input wire [15:0] base_pair,
    input wire table_data_valid,
    input wire [15:0] table_data,
    output reg pc_load_q,
    output reg [AW-1:0] pc_target_q,
    output reg mem_valid_q,
    output reg [AW-1:0] mem_addr_q,
    output reg mem_is_table_q,
    output reg mem_in_ram_q,
    output reg mem_in_sfr_q,
    output reg stack_fault_q,
    output reg reg_valid_q,
    output reg reg_is_pair_q,
    output reg [2:0] reg_index_q,
    output reg busy_q,
    output reg [AW-1:0] sp_q
);

    localparam ST_IDLE = 2'b01;
    localparam ST_TABLE = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;

    function [15:0] pair_value;
        input [1:0] sel;
        input [15:0] a;
        input [15:0] c;
        input [15:0] d;
        input [15:0] h;
        begin
            if (sel == `CAG_PAIR_ACC) begin
                pair_value = a;
            end else if (sel == `CAG_PAIR_CNT) begin
                pair_value = c;
            end else if (sel == `CAG_PAIR_IDX) begin
                pair_value = d;
            end else begin
                pair_value = h;
            end
        end
    endfunction

    function in_ram;
        input [15:0] a;
        begin
            in_ram = (a >= `CAG_SHORT_LOW) && (a <= `CAG_RAM_LAST);
        end
    endfunction

    wire [15:0] short_addr = {`CAG_UPPER_ONES, (byte_operand < `CAG_SHORT_SPLIT), byte_operand};
    wire [15:0] sfr_addr = `CAG_SFR_BASE | {8'h00, byte_operand};
    wire [15:0] based_addr = base_pair + {8'h00, byte_operand};
    wire [15:0] rel_addr = next_pc + {{8{jump_displacement[7]}}, jump_displacement};
    wire [4:0] slot = opcode[`CAG_SLOT_MSB:`CAG_SLOT_LSB];
    wire [15:0] table_addr = `CAG_TABLE_BASE | {10'h000, slot, 1'b0};
    wire [1:0] indir_sel = pair_select_field[0] ? `CAG_PAIR_BASE : `CAG_PAIR_IDX;
    wire [15:0] sp_dec = sp_q - 16'h0001;
    wire [15:0] sp_inc = sp_q + 16'h0001;

    function [15:0] mem_addr_d_peek;
        input [3:0] m;
        begin
            if (m == `CAG_M_DIRECT) begin
                mem_addr_d_peek = full_address_operand;
            end else if (m == `CAG_M_SHORT) begin
                mem_addr_d_peek = short_addr;
            end else if (m == `CAG_M_SFR) begin
                mem_addr_d_peek = sfr_addr;
            end else if (m == `CAG_M_INDIR) begin
                mem_addr_d_peek = pair_value(indir_sel, accumulator_pair, counter_pair, index_pair, base_pair);
            end else if (m == `CAG_M_BASED) begin
                mem_addr_d_peek = based_addr;
            end else if (m == `CAG_M_PUSH) begin
                mem_addr_d_peek = sp_dec;
            end else if (m == `CAG_M_POP) begin
                mem_addr_d_peek = sp_q;
            end else begin
                mem_addr_d_peek = table_addr;
            end
        end
    endfunction

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (req_valid && req_mode == `CAG_M_TABLE) begin
                    state_d = ST_TABLE;
                end
            end
            ST_TABLE: begin
                if (table_data_valid) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            pc_load_q <= 1'b0;
            pc_target_q <= 16'h0000;
            mem_valid_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_is_table_q <= 1'b0;
            mem_in_ram_q <= 1'b0;
            mem_in_sfr_q <= 1'b0;
            stack_fault_q <= 1'b0;
            reg_valid_q <= 1'b0;
            reg_is_pair_q <= 1'b0;
            reg_index_q <= 3'h0;
            busy_q <= 1'b0;
            sp_q <= `CAG_SP_RESET;
        end else begin
            state_q <= state_d;
            busy_q <= (state_d == ST_TABLE);
            pc_load_q <= 1'b0;
            mem_valid_q <= 1'b0;
            mem_is_table_q <= 1'b0;
            reg_valid_q <= 1'b0;
            stack_fault_q <= 1'b0;
            if (state_q == ST_TABLE) begin
                if (table_data_valid) begin
                    pc_load_q <= 1'b1;
                    pc_target_q <= table_data;
                end
            end else if (req_valid) begin
                case (req_mode)
                    `CAG_M_ABS: begin
                        pc_load_q <= 1'b1;
                        pc_target_q <= full_address_operand;
                    end
                    `CAG_M_TABLE: begin
                        mem_valid_q <= 1'b1;
                        mem_is_table_q <= 1'b1;
                        mem_addr_q <= table_addr;
                    end
                    `CAG_M_REGJMP: begin
                        pc_load_q <= 1'b1;
                        pc_target_q <= accumulator_pair;
                    end
                    `CAG_M_REL: begin
                        pc_load_q <= 1'b1;
                        pc_target_q <= rel_addr;
                    end
                    `CAG_M_DIRECT: begin
                        mem_valid_q <= 1'b1;
                        mem_addr_q <= full_address_operand;
                    end
                    `CAG_M_SHORT: begin
                        mem_valid_q <= 1'b1;
                        mem_addr_q <= short_addr;
                    end
                    `CAG_M_SFR: begin
                        mem_valid_q <= 1'b1;
                        mem_addr_q <= sfr_addr;
                    end
                    `CAG_M_REG: begin
                        reg_valid_q <= 1'b1;
                        reg_is_pair_q <= opcode[0];
                        reg_index_q <= opcode[0] ? {1'b0, pair_select_field} : reg_code;
                    end
                    `CAG_M_INDIR: begin
                        mem_valid_q <= 1'b1;
                        mem_addr_q <= pair_value(indir_sel, accumulator_pair, counter_pair,
                            index_pair, base_pair);
                    end
                    `CAG_M_BASED: begin
                        mem_valid_q <= 1'b1;
                        mem_addr_q <= based_addr;
                    end
                    `CAG_M_PUSH: begin
                        mem_valid_q <= 1'b1;
                        mem_addr_q <= sp_dec;
                        sp_q <= sp_dec;
                        stack_fault_q <= !in_ram(sp_dec);
                    end
                    `CAG_M_POP: begin
                        mem_valid_q <= 1'b1;
                        mem_addr_q <= sp_q;
                        sp_q <= sp_inc;
                        stack_fault_q <= !in_ram(sp_q);
                    end
                    default: begin
                        pc_load_q <= 1'b0;
                    end
                endcase
            end
            if (req_valid && state_q == ST_IDLE) begin
                mem_in_ram_q <= in_ram(mem_addr_d_peek(req_mode));
                mem_in_sfr_q <= mem_addr_d_peek(req_mode) >= `CAG_SFR_BASE;
            end
        end
    end

endmodule // cag_addr_gen

// ### sim/cag_addr_gen_properties.sv
`timescale 1ns/100ps
`include "cag_defs.vh"
module cag_chk #(
    parameter AW = 16
) (
    input logic clk_sys,
    input logic reset_n,
    input logic req_valid,
    input logic [3:0] req_mode,
    input logic [15:0] full_address_operand,
    input logic [7:0] opcode,
    input logic [7:0] byte_operand,
    input logic [7:0] jump_displacement,
    input logic [15:0] next_pc,
    input logic [15:0] accumulator_pair,
    input logic [15:0] base_pair,
    input logic table_data_valid,
    input logic [15:0] table_data,
    input logic pc_load_q,
    input logic [AW-1:0] pc_target_q,
    input logic mem_valid_q,
    input logic [AW-1:0] mem_addr_q,
    input logic mem_is_table_q,
    input logic busy_q,
    input logic [AW-1:0] sp_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire take = req_valid && !busy_q;
    chk_abs_target: assert property (take && req_mode == `CAG_M_ABS |=> pc_load_q
        && pc_target_q == $past(full_address_operand)) else $error("abs target wrong");
    chk_direct_addr: assert property (take && req_mode == `CAG_M_DIRECT |=> mem_valid_q
        && mem_addr_q == $past(full_address_operand)) else $error("direct address wrong");
    chk_short_addr: assert property (take && req_mode == `CAG_M_SHORT |=> mem_addr_q
        == {7'h7F, $past(byte_operand) < 8'h20, $past(byte_operand)}) else $error("short address wrong");
    chk_sfr_addr: assert property (take && req_mode == `CAG_M_SFR |=>
        mem_addr_q == {8'hFF, $past(byte_operand)}) else $error("sfr address wrong");
    chk_based_sum: assert property (take && req_mode == `CAG_M_BASED |=>
        mem_addr_q == $past(base_pair) + {8'h00, $past(byte_operand)}) else $error("based sum wrong");
    chk_table_fetch: assert property (take && req_mode == `CAG_M_TABLE |=> mem_is_table_q && busy_q
        && mem_addr_q == 16'h0040 + {10'h000, $past(opcode[5:1]), 1'b0}) else $error("table fetch wrong");
    chk_table_load: assert property (busy_q && table_data_valid |=> pc_load_q && !busy_q
        && pc_target_q == $past(table_data)) else $error("table load wrong");
    chk_push_predec: assert property (take && req_mode == `CAG_M_PUSH |=> mem_valid_q
        && sp_q == $past(sp_q) - 16'h0001 && mem_addr_q == sp_q) else $error("push address wrong");
    chk_pop_postinc: assert property (take && req_mode == `CAG_M_POP |=> mem_valid_q
        && sp_q == $past(sp_q) + 16'h0001 && mem_addr_q == $past(sp_q)) else $error("pop address wrong");
    chk_regjmp_target: assert property (take && req_mode == `CAG_M_REGJMP |=> pc_load_q
        && pc_target_q == $past(accumulator_pair)) else $error("register jump target wrong");
    chk_rel_target: assert property (take && req_mode == `CAG_M_REL |=> pc_load_q
        && pc_target_q == $past(next_pc) + {{8{$past(jump_displacement[7])}}, $past(jump_displacement)})
        else $error("relative target wrong");
endmodule // cag_chk
bind cag_addr_gen cag_chk #(.AW(AW)) u_cag_chk (.*);

// ### sim/testbench.sv
`timescale 1ns/100ps
`include "cag_defs.vh"
module testbench;
    reg clk_sys, reset_n, req_valid, table_data_valid;
    reg [3:0] req_mode;
    reg [15:0] full_address_operand, next_pc, accumulator_pair, counter_pair, index_pair, base_pair, table_data;
    reg [7:0] opcode, byte_operand, jump_displacement;
    reg [1:0] pair_select_field;
    reg [2:0] reg_code;
    wire pc_load_q, mem_valid_q, mem_is_table_q, mem_in_ram_q, mem_in_sfr_q, stack_fault_q;
    wire reg_valid_q, reg_is_pair_q, busy_q;
    wire [15:0] pc_target_q, mem_addr_q, sp_q;
    wire [2:0] reg_index_q;
    integer n_fail, samples_checked;
    cag_addr_gen u_cag_addr_gen (.*);
    always #5 clk_sys = ~clk_sys;
    task chk(input [15:0] e, input [15:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t expected %h got %h", $time, e, g);
            end
        end
    endtask
    task go(input [3:0] m);
        begin
            @(negedge clk_sys);
            req_mode = m;
            req_valid = 1'b1;
            @(negedge clk_sys);
            req_valid = 1'b0;
        end
    endtask
    task t_branch;
        begin
            full_address_operand = 16'hA5C3;
            go(`CAG_M_ABS);
            chk(16'hA5C3, pc_target_q);
            chk(16'h0001, {15'h0000, pc_load_q});
            go(`CAG_M_REGJMP);
            chk(16'h1234, pc_target_q);
            next_pc = 16'h1000;
            jump_displacement = 8'h80;
            go(`CAG_M_REL);
            chk(16'h0F80, pc_target_q);
            jump_displacement = 8'h7F;
            go(`CAG_M_REL);
            chk(16'h107F, pc_target_q);
        end
    endtask
    task t_operand;
        begin
            full_address_operand = 16'hFE00;
            go(`CAG_M_DIRECT);
            chk(16'hFE00, mem_addr_q);
            byte_operand = 8'h1F;
            go(`CAG_M_SHORT);
            chk(16'hFF1F, mem_addr_q);
            chk(16'h0001, {15'h0000, mem_in_sfr_q});
            byte_operand = 8'h20;
            go(`CAG_M_SHORT);
            chk(16'hFE20, mem_addr_q);
            chk(16'h0001, {15'h0000, mem_in_ram_q});
            byte_operand = 8'hF0;
            go(`CAG_M_SFR);
            chk(16'hFFF0, mem_addr_q);
            base_pair = 16'hFFF0;
            go(`CAG_M_BASED);
            chk(16'h00E0, mem_addr_q);
            pair_select_field = 2'h1;
            go(`CAG_M_INDIR);
            chk(16'hFFF0, mem_addr_q);
            pair_select_field = 2'h0;
            go(`CAG_M_INDIR);
            chk(16'hC0DE, mem_addr_q);
            opcode = 8'h01;
            pair_select_field = 2'h3;
            go(`CAG_M_REG);
            chk(16'h000F, {12'h000, reg_valid_q, reg_is_pair_q, reg_index_q[1:0]});
            opcode = 8'h00;
            reg_code = 3'h5;
            go(`CAG_M_REG);
            chk(16'h0015, {11'h000, reg_valid_q, reg_is_pair_q, reg_index_q});
        end
    endtask
    task t_table;
        begin
            opcode = 8'h3E;
            go(`CAG_M_TABLE);
            chk(16'h007E, mem_addr_q);
            chk(16'h0003, {14'h0000, mem_is_table_q, busy_q});
            go(`CAG_M_ABS);
            chk(16'h0000, {15'h0000, pc_load_q});
            table_data = 16'h8123;
            table_data_valid = 1'b1;
            @(negedge clk_sys);
            table_data_valid = 1'b0;
            chk(16'h8123, pc_target_q);
            chk(16'h0002, {14'h0000, pc_load_q, busy_q});
        end
    endtask
    task t_stack;
        begin
            chk(16'hFF00, sp_q);
            go(`CAG_M_PUSH);
            chk(16'hFEFF, mem_addr_q);
            chk(16'h0000, {15'h0000, stack_fault_q});
            go(`CAG_M_POP);
            chk(16'hFEFF, mem_addr_q);
            chk(16'hFF00, sp_q);
        end
    endtask
    task print_verdict;
        begin
            if (n_fail == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        {clk_sys, reset_n, req_valid, table_data_valid, req_mode, full_address_operand, next_pc} = 0;
        {opcode, byte_operand, jump_displacement, pair_select_field, reg_code, table_data} = 0;
        accumulator_pair = 16'h1234;
        counter_pair = 16'h5A5A;
        index_pair = 16'hC0DE;
        base_pair = 16'hB0B0;
        n_fail = 0;
        samples_checked = 0;
        repeat (5) @(negedge clk_sys);
        reset_n = 1'b1;
        t_stack;
        t_branch;
        t_operand;
        t_table;
        print_verdict;
    end
endmodule // testbench
